// ===== core/pecr_map.svh
/*
  Timing constants of the phase-encoded clock recovery front end.
  Assumes a 50 MHz system clock and a 120 kHz recorded bit rate.
*/
`ifndef PECR_MAP_SVH
`define PECR_MAP_SVH

// ==========================================================
// clock and data rates
`define PECR_CLK_HZ        50000000
`define PECR_BIT_RATE_HZ   120000
`define PECR_CELL_TICKS    24
// loop oscillator period in system clocks, rounded down
`define PECR_OSC_DIV       (`PECR_CLK_HZ / (`PECR_BIT_RATE_HZ * `PECR_CELL_TICKS))
`define PECR_OSC_HALF      (`PECR_OSC_DIV / 2)

// ==========================================================
// window counter
`define PECR_HALF_CELL     (`PECR_CELL_TICKS / 2)
`define PECR_THIRD_CELL    (`PECR_CELL_TICKS / 3)
`define PECR_FULL_COUNT    (`PECR_HALF_CELL + `PECR_THIRD_CELL)

// ==========================================================
// gap oscillator, one oscillator period slower than a data cell
`define PECR_GAP_CYC       ((`PECR_CELL_TICKS + 1) * `PECR_OSC_DIV)

`endif

// ===== core/pecr_pkg.sv
/*
  Types of the phase-encoded clock recovery front end.
  Assumes pecr_map.svh is on the include path.
*/
package pecr_pkg;

  // ========================================================
  // extraction state
  typedef enum logic [2:0] {
    PECR_IDLE  = 3'b001,
    PECR_ARMED = 3'b010,
    PECR_TRACK = 3'b100
  } pecr_state_e;

  typedef logic [4:0] pecr_cnt_t;
  typedef logic [8:0] pecr_gap_t;

endpackage : pecr_pkg

// ===== core/pecr_extract.sv
/*
  Midpoint pulse extractor and reference selector for a clock recovery loop.
  Assumes DATA_IN and DATA_GATE are asynchronous pins; REF_PULSE feeds the
  reference input of an external phase detector.
*/
// How it works
// - a zero cell is a rising edge at mid cell.
// - a one cell is a falling edge at mid cell.
// - extra edges sit only at cell boundaries, masked here.
// - one reference pulse per cell, at its midpoint.
// - loop oscillator ticks twenty-four times per bit cell.
// - data copy resampled once per oscillator period, at its half-way point.
// - transition pulse is data xor delayed copy, gated.
// - gate initialises logic so the first transition gives no pulse.
// - first transition closes the window and clears the counter.
// - counter full count opens the window until next transition.
// - every accepted pulse clears the counter again.
// - during gaps the reference is a slightly slow oscillator.
// - with data present the reference is the midpoint pulse.
`timescale 1ns/1ps
`include "pecr_map.svh"

module pecr_extract (
  // clock and reset
  input  wire logic MCLK,
  input  wire logic RST_N,
  // tape read channel
  input  wire logic DATA_IN,
  input  wire logic DATA_GATE,
  // phase detector reference
  output logic      REF_PULSE,
  // recovered cells
  output logic      MID_PULSE,
  output logic      BIT_VALUE,
  output logic      WINDOW_OPEN
);
  import pecr_pkg::*;

  localparam int FULL_N = `PECR_FULL_COUNT;

  // ========================================================
  // pin synchronisers
  logic data_m;
  logic data_s;
  logic gate_m;
  logic gate_s;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      data_m <= 1'b0;
      data_s <= 1'b0;
      gate_m <= 1'b0;
      gate_s <= 1'b0;
    end else begin
      data_m <= DATA_IN;
      data_s <= data_m;
      gate_m <= DATA_GATE;
      gate_s <= gate_m;
    end
  end

  // ========================================================
  // loop oscillator: full and half period enables
  pecr_cnt_t div_cnt;
  pecr_cnt_t next_div_cnt;
  logic      osc_tick;
  logic      half_tick;
  logic      next_osc_tick;
  logic      next_half_tick;

  always_comb begin
    next_div_cnt   = div_cnt + 5'h01;
    next_osc_tick  = 1'b0;
    next_half_tick = 1'b0;
    if (div_cnt == 5'(`PECR_OSC_DIV - 1)) begin
      next_div_cnt  = 5'h00;
      next_osc_tick = 1'b1;
    end
    if (div_cnt == 5'(`PECR_OSC_HALF - 1)) begin
      next_half_tick = 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      div_cnt   <= 5'h00;
      osc_tick  <= 1'b0;
      half_tick <= 1'b0;
    end else begin
      div_cnt   <= next_div_cnt;
      osc_tick  <= next_osc_tick;
      half_tick <= next_half_tick;
    end
  end

  // ========================================================
  // transition detector
  logic delayed;
  logic next_delayed;
  logic xor_q;
  logic xor_now;
  logic trans;

  always_comb begin
    next_delayed = delayed;
    if (half_tick) begin
      next_delayed = data_s;
    end
    xor_now = data_s ^ delayed;
    // edge of the xor so a long difference still counts once
    trans   = xor_now & ~xor_q;
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      delayed <= 1'b0;
      xor_q   <= 1'b0;
    end else begin
      delayed <= next_delayed;
      xor_q   <= xor_now;
    end
  end

  // ========================================================
  // window counter and inhibit latch
  pecr_state_e state;
  pecr_state_e next_state;
  pecr_cnt_t   cell_cnt;
  pecr_cnt_t   next_cell_cnt;
  logic        window_open;
  logic        next_window_open;
  logic        accept;

  always_comb begin
    next_state       = state;
    next_cell_cnt    = cell_cnt;
    next_window_open = window_open;
    accept           = 1'b0;
    unique case (state)
      PECR_IDLE: begin
        next_cell_cnt    = 5'h00;
        next_window_open = 1'b0;
        if (gate_s) begin
          next_state = PECR_ARMED;
        end
      end
      PECR_ARMED: begin
        // first edge of a block is a midpoint edge: swallow it
        if (trans) begin
          next_cell_cnt    = 5'h00;
          next_window_open = 1'b0;
          next_state       = PECR_TRACK;
        end
      end
      PECR_TRACK: begin
        accept = trans & window_open;
        if (accept) begin
          next_cell_cnt    = 5'h00;
          next_window_open = 1'b0;
        end else begin
          if (osc_tick && cell_cnt != 5'(FULL_N)) begin
            next_cell_cnt = cell_cnt + 5'h01;
          end
          if (cell_cnt == 5'(FULL_N)) begin
            next_window_open = 1'b1;
          end
        end
      end
    endcase
    if (!gate_s) begin
      next_state       = PECR_IDLE;
      next_cell_cnt    = 5'h00;
      next_window_open = 1'b0;
      accept           = 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state       <= PECR_IDLE;
      cell_cnt    <= 5'h00;
      window_open <= 1'b0;
    end else begin
      state       <= next_state;
      cell_cnt    <= next_cell_cnt;
      window_open <= next_window_open;
    end
  end

  // ========================================================
  // gap oscillator, a little slower than the bit rate
  pecr_gap_t gap_cnt;
  pecr_gap_t next_gap_cnt;
  logic      gap_tick;

  always_comb begin
    gap_tick     = (gap_cnt == 9'(`PECR_GAP_CYC - 1));
    next_gap_cnt = gap_tick ? 9'h000 : gap_cnt + 9'h001;
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      gap_cnt <= 9'h000;
    end else begin
      gap_cnt <= next_gap_cnt;
    end
  end

  // ========================================================
  // reference selector and outputs
  logic next_ref;
  logic next_bit;

  always_comb begin
    next_ref = gate_s ? accept : gap_tick;
    next_bit = BIT_VALUE;
    if (accept) begin
      // level after a midpoint edge: high means zero cell
      next_bit = ~data_s;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      REF_PULSE   <= 1'b0;
      MID_PULSE   <= 1'b0;
      BIT_VALUE   <= 1'b0;
      WINDOW_OPEN <= 1'b0;
    end else begin
      REF_PULSE   <= next_ref;
      MID_PULSE   <= accept;
      BIT_VALUE   <= next_bit;
      WINDOW_OPEN <= next_window_open;
    end
  end

  // ========================================================
  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  a_osc_period: assert property (
    osc_tick |=> (!osc_tick) [*8] ##1 (!osc_tick) [*8] ##0 !osc_tick
  ) else $error("loop oscillator period wrong");

  a_osc_spacing: assert property (
    osc_tick |-> ##17 osc_tick
  ) else $error("loop oscillator tick missing");

  a_delay_half: assert property (
    half_tick |=> delayed == $past(data_s)
  ) else $error("delayed copy not taken at half tick");

  a_first_ignored: assert property (
    (state == PECR_ARMED && trans && gate_s) |=> !MID_PULSE ##1 !MID_PULSE
  ) else $error("first transition produced a pulse");

  a_first_reset: assert property (
    (state == PECR_ARMED && trans && gate_s) |=> cell_cnt == 5'h00 && !window_open
  ) else $error("first transition did not clear counter");

  a_full_opens: assert property (
    (state == PECR_TRACK && gate_s && cell_cnt == 5'(FULL_N) && !trans)
      |=> window_open && WINDOW_OPEN
  ) else $error("full count did not open window");

  a_pulse_clears: assert property (
    MID_PULSE |-> cell_cnt == 5'h00 && !window_open
  ) else $error("accepted pulse did not restart window");

  a_masked_edge: assert property (
    (state == PECR_TRACK && !window_open && trans) |=> !MID_PULSE
  ) else $error("boundary edge passed while inhibited");

  a_gap_ref: assert property (
    (!gate_s && gap_tick) |=> REF_PULSE && !MID_PULSE
  ) else $error("gap oscillator not on reference");

  a_data_ref: assert property (
    (gate_s && accept) |=> REF_PULSE && MID_PULSE
  ) else $error("midpoint pulse not on reference");

  a_bit_level: assert property (
    MID_PULSE |-> BIT_VALUE == !$past(data_s)
  ) else $error("cell value does not follow edge direction");

  c_first_accept: cover property (
    state == PECR_TRACK && accept
  );

  c_one_cell: cover property (
    MID_PULSE && BIT_VALUE
  );

  c_gap_ref: cover property (
    !gate_s && REF_PULSE
  );

endmodule : pecr_extract

// ===== verif/pecr_tape.sv
/*
  Tape read channel model: phase-encoded cells and the data-present gate.
  Assumes the bench owns MCLK; a cell lasts 408 system clocks.
*/
`timescale 1ns/1ps

module pecr_tape (
  // clock
  input  wire logic MCLK,
  // tape read channel
  output logic      DATA_IN,
  output logic      DATA_GATE
);
  int   cyc     = 0;
  int   mid_at  = 0;
  logic cur_bit = 1'b0;

  // ========================================================
  // line idles low so the first edge of a block is a midpoint
  initial begin
    DATA_IN   = 1'b0;
    DATA_GATE = 1'b0;
  end

  always @(posedge MCLK) begin
    cyc <= cyc + 1;
  end

  task automatic set_gate(input logic g);
    @(posedge MCLK);
    DATA_GATE <= g;
  endtask : set_gate

  // ========================================================
  // one cell, 204 clocks per half cell
  task automatic send_cell(input logic b);
    @(posedge MCLK);
    DATA_IN <= b;
    repeat (204) @(posedge MCLK);
    DATA_IN <= ~b;
    mid_at  = cyc;
    cur_bit = b;
    repeat (203) @(posedge MCLK);
  endtask : send_cell

  // cells sent msb first
  task automatic play(input logic [31:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      send_cell(bits[i]);
    end
  endtask : play

  // ========================================================
  // one block on one track: each character is one cell here
  task automatic send_block(input logic [17:0] chars);
    repeat (40) send_cell(1'b0);
    send_cell(1'b1);
    for (int i = 17; i >= 0; i--) begin
      send_cell(chars[i]);
    end
    send_cell(1'b1);
    repeat (40) send_cell(1'b0);
    // erased gap: back to the idle level so the next block starts clean
    @(posedge MCLK);
    DATA_IN <= 1'b0;
  endtask : send_block
endmodule : pecr_tape

// ===== verif/tb_top.sv
/*
  Self-checking bench for the midpoint pulse extractor.
  Assumes pecr_tape drives the read channel; all counts in MCLK cycles.
*/
`timescale 1ns/1ps

module tb_top;
  logic        MCLK;
  logic        RST_N;
  logic        DATA_IN;
  logic        DATA_GATE;
  logic        REF_PULSE;
  logic        MID_PULSE;
  logic        BIT_VALUE;
  logic        WINDOW_OPEN;
  logic        in_data = 1'b0;
  logic        wo_q    = 1'b0;
  int          n_one     = 0;
  int          bad_count = 0;
  int          checks    = 0;
  int          n_mid     = 0;
  int          last_mid  = 0;

  pecr_extract DUT (
    .MCLK(MCLK), .RST_N(RST_N), .DATA_IN(DATA_IN), .DATA_GATE(DATA_GATE),
    .REF_PULSE(REF_PULSE), .MID_PULSE(MID_PULSE), .BIT_VALUE(BIT_VALUE),
    .WINDOW_OPEN(WINDOW_OPEN)
  );

  pecr_tape DRV (.MCLK(MCLK), .DATA_IN(DATA_IN), .DATA_GATE(DATA_GATE));

  // ========================================================
  // checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    if (bad_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  // ========================================================
  // pulse monitor, samples settled values at each edge
  always @(posedge MCLK) begin
    if (in_data && n_mid > 0 && WINDOW_OPEN === 1'b1 && wo_q !== 1'b1) begin
      check(DRV.cyc - last_mid inside {[320:360]}, 1'b1);
    end
    if (in_data && REF_PULSE === 1'b1) begin
      check(MID_PULSE, 1'b1);
    end
    if (MID_PULSE === 1'b1) begin
      check(REF_PULSE, 1'b1);
      check(WINDOW_OPEN, 1'b0);
      check(DRV.cyc - DRV.mid_at <= 25, 1'b1);
      if (n_mid > 0) begin
        check(DRV.cyc - last_mid inside {[390:426]}, 1'b1);
      end
      check(BIT_VALUE, DRV.cur_bit);
      last_mid = DRV.cyc;
      n_mid++;
      if (BIT_VALUE === 1'b1) begin
        n_one++;
      end
    end
    wo_q = WINDOW_OPEN;
  end

  // ========================================================
  // scenarios
  task automatic s_reset;
    check({REF_PULSE, MID_PULSE, WINDOW_OPEN, BIT_VALUE}, 4'h0);
  endtask : s_reset

  // gap ticks while cells pass with the gate low
  task automatic s_gap;
    int t0;
    int n;
    t0 = 0;
    n  = 0;
    fork
      DRV.play(32'h1, 2);
      for (int i = 0; i < 900 && n < 2; i++) begin
        @(posedge MCLK);
        if (MID_PULSE === 1'b1) check(1'b0, 1'b1);
        if (REF_PULSE === 1'b1) begin
          if (n == 1) check(DRV.cyc - t0, 425);
          t0 = DRV.cyc;
          n++;
        end
      end
    join
    if (n != 2) begin
      check(n, 2);
      report_and_stop;
    end
  endtask : s_gap

  // full block: preamble, 18 characters, postamble
  task automatic s_block;
    logic [17:0] chars;
    chars = 18'h2d39b;
    DRV.set_gate(1'b1);
    repeat (8) @(posedge MCLK);
    in_data <= 1'b1;
    DRV.send_block(chars);
    repeat (30) @(posedge MCLK);
    in_data <= 1'b0;
    DRV.set_gate(1'b0);
    // 100 cells, the first edge swallowed, one pulse for each of the other 99 cells
    check(n_mid, 99);
    check(n_one, 2 + $countones(chars));
  endtask : s_block

  // ========================================================
  // clock, reset and sequence
  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end

  initial begin
    RST_N = 1'b0;
    repeat (19) @(posedge MCLK);
    s_reset;
    @(posedge MCLK);
    RST_N <= 1'b1;
    s_gap;
    s_block;
    report_and_stop;
  end
endmodule : tb_top
